// >>> core/rac_regs.svh
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

// Register byte offsets
`define RAC_OFF_CFG      8'h00
`define RAC_OFF_MINUTES_SECONDS_VALUE   8'h04
`define RAC_OFF_PAD      8'h08
`define RAC_OFF_ALCFG    8'h0C
`define RAC_OFF_IRQ_STAT 8'h10
`define RAC_OFF_IRQ_MASK 8'h14

// Clock configuration and calibration fields
`define RAC_CFG_RUN_BIT  15
`define RAC_CFG_WREN_BIT 13
`define RAC_CFG_HALF_BIT 11
`define RAC_CFG_OE_BIT   10
`define RAC_CFG_CAL_MSB  7
`define RAC_CFG_RST      16'h0000

// Pad output configuration fields
`define RAC_PAD_SEL_BIT  1
`define RAC_PAD_RST      16'h0000

// Alarm configuration and repeat fields
`define RAC_AL_EN_BIT    15
`define RAC_AL_REPEAT_WRAP_ENABLE_BIT 14
`define RAC_AL_MASK_MSB  13
`define RAC_AL_MASK_LSB  10
`define RAC_AL_PTR_MSB   9
`define RAC_AL_PTR_LSB   8
`define RAC_AL_RPT_MSB   7
`define RAC_AL_RST       16'h0000

// Interrupt status and mask fields
`define RAC_IRQ_ALARM_BIT 0
`define RAC_IRQ_OFF_BIT   1
`define RAC_IRQ_RST       2'h0

`endif

// >>> core/rac_pkg.sv
package rac_pkg;

	// AXI response codes in encoding order
	typedef enum logic [1:0] {RAC_OKAY, RAC_EXOKAY, RAC_SLVERR} rac_resp_e;

	typedef logic [15:0] rac_half_t;
	typedef logic [7:0]  rac_count_t;

endpackage

// >>> core/rac_axil_slave.sv
`timescale 1ns/1ps

module rac_axil_slave (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  s_awaddr_i,
	input  wire logic        s_awvalid_i,
	output logic             s_awready_o,
	input  wire logic [31:0] s_wdata_i,
	input  wire logic [3:0]  s_wstrb_i,
	input  wire logic        s_wvalid_i,
	output logic             s_wready_o,
	output logic [1:0]       s_bresp_o,
	output logic             s_bvalid_o,
	input  wire logic        s_bready_i,
	input  wire logic [7:0]  s_araddr_i,
	input  wire logic        s_arvalid_i,
	output logic             s_arready_o,
	output logic [31:0]      s_rdata_o,
	output logic [1:0]       s_rresp_o,
	output logic             s_rvalid_o,
	input  wire logic        s_rready_i,
	output logic             wr_en_o,
	output logic [7:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	output logic [3:0]       wr_strb_o,
	input  wire logic        wr_err_i,
	output logic             rd_en_o,
	output logic [7:0]       rd_addr_o,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_err_i
);
	logic aw_hold_r;
	logic w_hold_r;

	// Channel readiness and one-cycle register strobes
	assign s_awready_o = !aw_hold_r;
	assign s_wready_o  = !w_hold_r;
	assign s_arready_o = !s_rvalid_o;
	assign wr_en_o     = aw_hold_r && w_hold_r && !s_bvalid_o;
	assign rd_en_o     = s_arvalid_i && s_arready_o;
	assign rd_addr_o   = s_araddr_i;

	// Address and data may arrive in either order
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 32'h0000_0000;
			wr_strb_o <= 4'h0;
		end
		else
		begin
			if (s_awvalid_i && s_awready_o)
			begin
				aw_hold_r <= 1'b1;
				wr_addr_o <= s_awaddr_i;
			end
			else if (wr_en_o)
				aw_hold_r <= 1'b0;
			if (s_wvalid_i && s_wready_o)
			begin
				w_hold_r  <= 1'b1;
				wr_data_o <= s_wdata_i;
				wr_strb_o <= s_wstrb_i;
			end
			else if (wr_en_o)
				w_hold_r <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_bvalid_o <= 1'b0;
			s_bresp_o  <= 2'h0;
		end
		else if (wr_en_o)
		begin
			s_bvalid_o <= 1'b1;
			s_bresp_o  <= wr_err_i ? rac_pkg::RAC_SLVERR : rac_pkg::RAC_OKAY;
		end
		else if (s_bready_i)
			s_bvalid_o <= 1'b0;
	end

	// Read response, data captured from the register mux
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_rvalid_o <= 1'b0;
			s_rresp_o  <= 2'h0;
			s_rdata_o  <= 32'h0000_0000;
		end
		else if (rd_en_o)
		begin
			s_rvalid_o <= 1'b1;
			s_rresp_o  <= rd_err_i ? rac_pkg::RAC_SLVERR : rac_pkg::RAC_OKAY;
			s_rdata_o  <= rd_data_i;
		end
		else if (s_rready_i)
			s_rvalid_o <= 1'b0;
	end
endmodule // rac_axil_slave

// >>> core/rac_repeat_ctr.sv
`timescale 1ns/1ps

module rac_repeat_ctr #(
	parameter int CNT_W = 8
) (
	input  wire logic             alarm_evt_i,
	input  wire logic             wrap_en_i,
	input  wire logic [CNT_W-1:0] count_i,
	output logic [CNT_W-1:0]      count_nxt_o,
	output logic                  alarm_off_o
);
	// Step the count down, wrapping only when allowed
	function automatic logic [CNT_W-1:0] step_down(input logic [CNT_W-1:0] c,
			input logic wrap);
		if (c != '0)
			step_down = c - CNT_W'(1);
		else if (wrap)
			step_down = '1;
		else
			step_down = '0;
	endfunction

	// Next repeat count and automatic alarm shut-off
	always_comb
	begin
		count_nxt_o = count_i;
		alarm_off_o = 1'b0;
		if (alarm_evt_i)
		begin
			count_nxt_o = step_down(count_i, wrap_en_i);
			alarm_off_o = (count_i == '0) && !wrap_en_i;
		end
	end
endmodule // rac_repeat_ctr

// >>> core/rac_top.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "rac_regs.svh"

module rac_top #(
	parameter int RPT_W = 8
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        por_nrst_i,
	input  wire logic [7:0]  s_awaddr_i,
	input  wire logic        s_awvalid_i,
	output logic             s_awready_o,
	input  wire logic [31:0] s_wdata_i,
	input  wire logic [3:0]  s_wstrb_i,
	input  wire logic        s_wvalid_i,
	output logic             s_wready_o,
	output logic [1:0]       s_bresp_o,
	output logic             s_bvalid_o,
	input  wire logic        s_bready_i,
	input  wire logic [7:0]  s_araddr_i,
	input  wire logic        s_arvalid_i,
	output logic             s_arready_o,
	output logic [31:0]      s_rdata_o,
	output logic [1:0]       s_rresp_o,
	output logic             s_rvalid_o,
	input  wire logic        s_rready_i,
	input  wire logic        seconds_clk_i,
	input  wire logic        half_second_tick_i,
	input  wire logic        alarm_match_i,
	input  wire logic        alarm_value_access_i,
	output logic             calendar_clock_pin_o,
	output logic             clock_run_enable_o,
	output logic [3:0]       alarm_interval_mask_o,
	output logic [1:0]       alarm_value_pointer_o,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;

	rac_axil_slave u_bus (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.s_awaddr_i  (s_awaddr_i),
		.s_awvalid_i (s_awvalid_i),
		.s_awready_o (s_awready_o),
		.s_wdata_i   (s_wdata_i),
		.s_wstrb_i   (s_wstrb_i),
		.s_wvalid_i  (s_wvalid_i),
		.s_wready_o  (s_wready_o),
		.s_bresp_o   (s_bresp_o),
		.s_bvalid_o  (s_bvalid_o),
		.s_bready_i  (s_bready_i),
		.s_araddr_i  (s_araddr_i),
		.s_arvalid_i (s_arvalid_i),
		.s_arready_o (s_arready_o),
		.s_rdata_o   (s_rdata_o),
		.s_rresp_o   (s_rresp_o),
		.s_rvalid_o  (s_rvalid_o),
		.s_rready_i  (s_rready_i),
		.wr_en_o     (wr_en),
		.wr_addr_o   (wr_addr),
		.wr_data_o   (wr_data),
		.wr_strb_o   (wr_strb),
		.wr_err_i    (wr_err),
		.rd_en_o     (rd_en),
		.rd_addr_o   (rd_addr),
		.rd_data_i   (rd_data),
		.rd_err_i    (rd_err)
	);

	// True when an offset names a register
	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			`RAC_OFF_CFG, `RAC_OFF_MINUTES_SECONDS_VALUE, `RAC_OFF_PAD,
			`RAC_OFF_ALCFG, `RAC_OFF_IRQ_STAT, `RAC_OFF_IRQ_MASK:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	assign wr_err = !is_mapped(wr_addr);
	assign rd_err = !is_mapped(rd_addr);

	// ------------------------------------------------------------
	// Write strobes per register and the status read strobe
	// ------------------------------------------------------------
	logic cfg_wr_lo;
	logic cfg_wr_hi;
	logic min_wr_lo;
	logic min_wr_hi;
	logic pad_wr;
	logic al_wr_lo;
	logic al_wr_hi;
	logic mask_wr;
	logic stat_rd;

	assign cfg_wr_lo = wr_en && wr_addr == `RAC_OFF_CFG && wr_strb[0];
	assign cfg_wr_hi = wr_en && wr_addr == `RAC_OFF_CFG && wr_strb[1];
	assign min_wr_lo = wr_en && wr_addr == `RAC_OFF_MINUTES_SECONDS_VALUE && wr_strb[0];
	assign min_wr_hi = wr_en && wr_addr == `RAC_OFF_MINUTES_SECONDS_VALUE && wr_strb[1];
	assign pad_wr    = wr_en && wr_addr == `RAC_OFF_PAD && wr_strb[0];
	assign al_wr_lo  = wr_en && wr_addr == `RAC_OFF_ALCFG && wr_strb[0];
	assign al_wr_hi  = wr_en && wr_addr == `RAC_OFF_ALCFG && wr_strb[1];
	assign mask_wr   = wr_en && wr_addr == `RAC_OFF_IRQ_MASK && wr_strb[0];
	assign stat_rd   = rd_en && rd_addr == `RAC_OFF_IRQ_STAT;

	// ------------------------------------------------------------
	// Clock configuration and calibration
	// ------------------------------------------------------------
	logic       run_en_r;
	logic       val_wren_r;
	logic       half_sec_r;
	logic       out_en_r;
	logic [7:0] cal_r;

	// Held across system resets, cleared by power-on only
	always_ff @(posedge clk_i or negedge por_nrst_i)
	begin
		if (!por_nrst_i)
		begin
			run_en_r   <= 1'(`RAC_CFG_RST >> `RAC_CFG_RUN_BIT);
			val_wren_r <= 1'(`RAC_CFG_RST >> `RAC_CFG_WREN_BIT);
			out_en_r   <= 1'(`RAC_CFG_RST >> `RAC_CFG_OE_BIT);
			cal_r      <= 8'(`RAC_CFG_RST);
		end
		else
		begin
			if (cfg_wr_lo)
				cal_r <= wr_data[`RAC_CFG_CAL_MSB:0];
			if (cfg_wr_hi)
			begin
				val_wren_r <= wr_data[`RAC_CFG_WREN_BIT];
				out_en_r   <= wr_data[`RAC_CFG_OE_BIT];
				if (val_wren_r)
					run_en_r <= wr_data[`RAC_CFG_RUN_BIT];
			end
		end
	end

	// Half-second flag toggles on tick, a minutes/seconds low-byte write zeroes it
	always_ff @(posedge clk_i or negedge por_nrst_i)
	begin
		if (!por_nrst_i)
			half_sec_r <= 1'(`RAC_CFG_RST >> `RAC_CFG_HALF_BIT);
		else if (min_wr_lo)
			half_sec_r <= 1'b0;
		else if (half_second_tick_i)
			half_sec_r <= !half_sec_r;
	end

	// ------------------------------------------------------------
	// Minutes and seconds value
	// ------------------------------------------------------------
	logic [15:0] minutes_seconds_value_r;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			minutes_seconds_value_r <= 16'h0000;
		else
		begin
			if (min_wr_lo)
				minutes_seconds_value_r[7:0] <= wr_data[7:0];
			if (min_wr_hi)
				minutes_seconds_value_r[15:8] <= wr_data[15:8];
		end
	end

	// ------------------------------------------------------------
	// Pad output configuration and pin
	// ------------------------------------------------------------
	logic src_sel_r;
	logic alarm_pulse_r;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			src_sel_r <= 1'(`RAC_PAD_RST >> `RAC_PAD_SEL_BIT);
		else if (pad_wr)
			src_sel_r <= wr_data[`RAC_PAD_SEL_BIT];
	end

	// Pin driven from a flop: selected source gated by output enable
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			calendar_clock_pin_o <= 1'b0;
		else if (out_en_r)
			calendar_clock_pin_o <= src_sel_r ? seconds_clk_i : alarm_pulse_r;
		else
			calendar_clock_pin_o <= 1'b0;
	end

	// ------------------------------------------------------------
	// Alarm configuration and repeat
	// ------------------------------------------------------------
	logic             al_en_r;
	logic             repeat_wrap_enable_r;
	logic [3:0]       alarm_interval_mask_r;
	logic [1:0]       aptr_r;
	logic [RPT_W-1:0] rpt_r;
	logic [RPT_W-1:0] rpt_nxt;
	logic             al_off;
	logic             alarm_evt;

	assign alarm_evt = alarm_match_i && al_en_r;

	rac_repeat_ctr #(.CNT_W(RPT_W)) u_rpt (
		.alarm_evt_i (alarm_evt),
		.wrap_en_i   (repeat_wrap_enable_r),
		.count_i     (rpt_r),
		.count_nxt_o (rpt_nxt),
		.alarm_off_o (al_off)
	);

	// Upper byte: enable, wrap, mask, pointer; writes beat hardware
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			al_en_r <= 1'(`RAC_AL_RST >> `RAC_AL_EN_BIT);
			repeat_wrap_enable_r <= 1'(`RAC_AL_RST >> `RAC_AL_REPEAT_WRAP_ENABLE_BIT);
			alarm_interval_mask_r <= 4'(`RAC_AL_RST >> `RAC_AL_MASK_LSB);
			aptr_r  <= 2'(`RAC_AL_RST >> `RAC_AL_PTR_LSB);
		end
		else if (al_wr_hi)
		begin
			al_en_r <= wr_data[`RAC_AL_EN_BIT];
			repeat_wrap_enable_r <= wr_data[`RAC_AL_REPEAT_WRAP_ENABLE_BIT];
			alarm_interval_mask_r <= wr_data[`RAC_AL_MASK_MSB:`RAC_AL_MASK_LSB];
			aptr_r  <= wr_data[`RAC_AL_PTR_MSB:`RAC_AL_PTR_LSB];
		end
		else
		begin
			if (al_off)
				al_en_r <= 1'b0;
			if (alarm_value_access_i && aptr_r != 2'h0)
				aptr_r <= aptr_r - 2'h1;
		end
	end

	// Repeat count and the alarm pulse toggle
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rpt_r         <= RPT_W'(`RAC_AL_RST);
			alarm_pulse_r <= 1'b0;
		end
		else
		begin
			if (al_wr_lo)
				rpt_r <= wr_data[RPT_W-1:0];
			else
				rpt_r <= rpt_nxt;
			if (alarm_evt)
				alarm_pulse_r <= !alarm_pulse_r;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic [1:0] irq_set;

	assign irq_set = {al_off, alarm_evt};

	// Sticky status, read clears, a new event wins over the clear
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			irq_stat_r <= `RAC_IRQ_RST;
			irq_mask_r <= `RAC_IRQ_RST;
		end
		else
		begin
			irq_stat_r <= (stat_rd ? 2'h0 : irq_stat_r) | irq_set;
			if (mask_wr)
				irq_mask_r <= wr_data[1:0];
		end
	end

	assign irq_o = |(irq_stat_r & irq_mask_r);

	// ------------------------------------------------------------
	// Read mux and plain outputs
	// ------------------------------------------------------------
	always_comb
	begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			`RAC_OFF_CFG:
			begin
				rd_data[`RAC_CFG_RUN_BIT]     = run_en_r;
				rd_data[`RAC_CFG_WREN_BIT]    = val_wren_r;
				rd_data[`RAC_CFG_HALF_BIT]    = half_sec_r;
				rd_data[`RAC_CFG_OE_BIT]      = out_en_r;
				rd_data[`RAC_CFG_CAL_MSB:0]   = cal_r;
			end
			`RAC_OFF_MINUTES_SECONDS_VALUE:   rd_data[15:0] = minutes_seconds_value_r;
			`RAC_OFF_PAD:      rd_data[`RAC_PAD_SEL_BIT] = src_sel_r;
			`RAC_OFF_ALCFG:
				rd_data[15:0] = {al_en_r, repeat_wrap_enable_r, alarm_interval_mask_r, aptr_r, rpt_r};
			`RAC_OFF_IRQ_STAT: rd_data[1:0] = irq_stat_r;
			`RAC_OFF_IRQ_MASK: rd_data[1:0] = irq_mask_r;
			default:           rd_data = 32'h0000_0000;
		endcase
	end

	assign clock_run_enable_o    = run_en_r;
	assign alarm_interval_mask_o = alarm_interval_mask_r;
	assign alarm_value_pointer_o = aptr_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [11:0] cfg_ctl;
	logic        pad_rd_q;

	assign cfg_ctl = {run_en_r, val_wren_r, out_en_r, cal_r, 1'b0};

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pad_rd_q <= 1'b0;
		else
			pad_rd_q <= rd_en && rd_addr == `RAC_OFF_PAD;
	end

	sequence seq_last_alarm;
		alarm_evt && rpt_r == '0 && !repeat_wrap_enable_r && !al_wr_hi && !al_wr_lo;
	endsequence

	sequence seq_alarm_off;
		!al_en_r && rpt_r == '0 && irq_stat_r[`RAC_IRQ_OFF_BIT];
	endsequence

	a_cfg_por_hold: assert property (@(posedge clk_i) disable iff (!por_nrst_i)
		!cfg_wr_lo && !cfg_wr_hi |=> $stable(cfg_ctl))
		else $error("config changed without a write");

	a_run_write_guard: assert property (@(posedge clk_i) disable iff (!por_nrst_i)
		cfg_wr_hi && !val_wren_r |=> run_en_r == $past(run_en_r))
		else $error("run enable written while locked");

	a_half_sec_clear: assert property (@(posedge clk_i) disable iff (!por_nrst_i)
		min_wr_lo |=> !half_sec_r ##1 (half_sec_r == $past(half_second_tick_i)))
		else $error("half-second flag not cleared");

	a_pin_source_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
		out_en_r && src_sel_r |=> calendar_clock_pin_o == $past(seconds_clk_i))
		else $error("pin does not follow seconds clock");

	a_pin_alarm_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
		out_en_r && !src_sel_r |=> calendar_clock_pin_o == $past(alarm_pulse_r))
		else $error("pin does not follow alarm pulse");

	a_pin_disabled: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!out_en_r |=> !calendar_clock_pin_o)
		else $error("pin active while output disabled");

	a_pad_read_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		pad_rd_q |-> s_rvalid_o && s_rdata_o[31:2] == '0 && !s_rdata_o[0])
		else $error("unimplemented pad bits read nonzero");

	a_repeat_no_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
		seq_last_alarm |=> rpt_r == '0)
		else $error("repeat count wrapped without repeat_wrap_enable");

	a_alarm_auto_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		seq_last_alarm |=> seq_alarm_off)
		else $error("alarm not disabled after last repeat");

	a_repeat_decrement: assert property (@(posedge clk_i) disable iff (!nrst_i)
		alarm_evt && rpt_r != '0 && !al_wr_lo |=> rpt_r == $past(rpt_r) - RPT_W'(1))
		else $error("repeat count did not decrement");
endmodule // rac_top

// >>> testbench/rac_top_tb_top.sv
`timescale 1ns/1ps
`include "rac_regs.svh"

module rac_top_tb_top;

	logic        clk_i;
	logic        nrst_i;
	logic        por_nrst_i;
	logic [7:0]  s_awaddr_i;
	logic        s_awvalid_i;
	logic        s_awready_o;
	logic [31:0] s_wdata_i;
	logic [3:0]  s_wstrb_i;
	logic        s_wvalid_i;
	logic        s_wready_o;
	logic [1:0]  s_bresp_o;
	logic        s_bvalid_o;
	logic        s_bready_i;
	logic [7:0]  s_araddr_i;
	logic        s_arvalid_i;
	logic        s_arready_o;
	logic [31:0] s_rdata_o;
	logic [1:0]  s_rresp_o;
	logic        s_rvalid_o;
	logic        s_rready_i;
	logic        seconds_clk_i;
	logic        half_second_tick_i;
	logic        alarm_match_i;
	logic        alarm_value_access_i;
	logic        pin;
	logic        run;
	logic [3:0]  alarm_interval_mask;
	logic [1:0]  aptr;
	logic        irq_o;
	logic [33:0] exp_q[$];
	logic [1:0]  expb_q[$];
	int          n_errors;
	int          n_tests;
	logic        tog;
	logic        b;
	int          n;

	localparam logic [1:0] OK = rac_pkg::RAC_OKAY;
	localparam logic [1:0] ERR = rac_pkg::RAC_SLVERR;

	rac_top dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .por_nrst_i(por_nrst_i),
		.s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
		.s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i),
		.s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o),
		.s_bready_i(s_bready_i), .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
		.s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
		.s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .seconds_clk_i(seconds_clk_i),
		.half_second_tick_i(half_second_tick_i), .alarm_match_i(alarm_match_i),
		.alarm_value_access_i(alarm_value_access_i), .calendar_clock_pin_o(pin),
		.clock_run_enable_o(run), .alarm_interval_mask_o(alarm_interval_mask),
		.alarm_value_pointer_o(aptr), .irq_o(irq_o)
	);

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial
	begin
		#200000;
		n_errors++;
		close_out();
	end

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		n_tests++;
		if (seen !== want)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// Read and write answers are matched against the oldest note
	always @(posedge clk_i)
	begin
		if (s_rvalid_o === 1'b1 && s_rready_i === 1'b1)
			chk({s_rresp_o, s_rdata_o}, exp_q.pop_front());
		if (s_bvalid_o === 1'b1 && s_bready_i === 1'b1)
			chk(34'(s_bresp_o), 34'(expb_q.pop_front()));
	end

	task automatic close_out();
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
			input logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		expb_q.push_back(r);
		@(posedge clk_i);
		s_awaddr_i <= a;
		s_wdata_i <= {16'h0000, d};
		s_wstrb_i <= s;
		s_awvalid_i <= 1'b1;
		s_wvalid_i <= 1'b1;
		s_bready_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (!aw && s_awready_o === 1'b1)
			begin
				aw = 1'b1;
				s_awvalid_i <= 1'b0;
			end
			if (!w && s_wready_o === 1'b1)
			begin
				w = 1'b1;
				s_wvalid_i <= 1'b0;
			end
		end while (s_bvalid_o !== 1'b1);
		s_bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		@(posedge clk_i);
		s_araddr_i <= a;
		s_arvalid_i <= 1'b1;
		s_rready_i <= 1'b1;
		exp_q.push_back({r, 16'h0000, d});
		do
		begin
			@(posedge clk_i);
			if (s_arready_o === 1'b1)
				s_arvalid_i <= 1'b0;
		end while (s_rvalid_o !== 1'b1);
		s_rready_i <= 1'b0;
	endtask

	// One alarm match pulse
	task automatic ev();
		@(posedge clk_i);
		alarm_match_i <= 1'b1;
		@(posedge clk_i);
		alarm_match_i <= 1'b0;
	endtask

	task automatic pin_chk(input logic e);
		repeat (2) @(posedge clk_i);
		#1 chk(34'(pin), 34'(e));
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{nrst_i, por_nrst_i, s_awvalid_i, s_wvalid_i, s_bready_i} = '0;
		{s_arvalid_i, s_rready_i, seconds_clk_i, half_second_tick_i} = '0;
		{alarm_match_i, alarm_value_access_i, s_awaddr_i, s_araddr_i} = '0;
		s_wdata_i = '0;
		s_wstrb_i = '0;
		n_errors = 0;
		n_tests = 0;
		tog = 1'b0;
		void'($urandom(32'h880C));
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		por_nrst_i <= 1'b1;
		// Reset values and unmapped place
		rd(`RAC_OFF_CFG, `RAC_CFG_RST, OK);
		rd(`RAC_OFF_PAD, `RAC_PAD_RST, OK);
		rd(`RAC_OFF_ALCFG, `RAC_AL_RST, OK);
		rd(8'h18, 16'h0000, ERR);
		wr(8'h18, 16'hFFFF, 4'hF, ERR);
		// Run enable guarded by value write enable
		wr(`RAC_OFF_CFG, 16'h8400, 4'hF, OK);
		rd(`RAC_OFF_CFG, 16'h0400, OK);
		wr(`RAC_OFF_CFG, 16'h2455, 4'hF, OK);
		wr(`RAC_OFF_CFG, 16'hA455, 4'hF, OK);
		#1 chk(34'(run), 34'h1);
		rd(`RAC_OFF_CFG, 16'hA455, OK);
		wr(`RAC_OFF_CFG, 16'h0455, 4'hF, OK);
		wr(`RAC_OFF_CFG, 16'h8455, 4'hF, OK);
		#1 chk(34'(run), 34'h0);
		rd(`RAC_OFF_CFG, 16'h0455, OK);
		// Pad select and pin routing
		wr(`RAC_OFF_PAD, 16'hFFFF, 4'hF, OK);
		rd(`RAC_OFF_PAD, 16'h0002, OK);
		repeat (6)
		begin
			b = 1'($urandom);
			@(posedge clk_i);
			seconds_clk_i <= b;
			repeat (2) @(posedge clk_i);
			pin_chk(b);
		end
		@(posedge clk_i);
		seconds_clk_i <= 1'b1;
		wr(`RAC_OFF_CFG, 16'h0055, 4'hF, OK);
		pin_chk(1'b0);
		wr(`RAC_OFF_CFG, 16'h0455, 4'hF, OK);
		wr(`RAC_OFF_PAD, 16'h0000, 4'hF, OK);
		pin_chk(1'b0);
		// Half-second flag
		@(posedge clk_i);
		half_second_tick_i <= 1'b1;
		@(posedge clk_i);
		half_second_tick_i <= 1'b0;
		wr(`RAC_OFF_CFG, 16'h0455, 4'hF, OK);
		rd(`RAC_OFF_CFG, 16'h0C55, OK);
		wr(`RAC_OFF_MINUTES_SECONDS_VALUE, 16'h3B00, 4'h2, OK);
		rd(`RAC_OFF_CFG, 16'h0C55, OK);
		wr(`RAC_OFF_MINUTES_SECONDS_VALUE, 16'h0027, 4'h1, OK);
		rd(`RAC_OFF_CFG, 16'h0455, OK);
		rd(`RAC_OFF_MINUTES_SECONDS_VALUE, 16'h3B27, OK);
		// Repeat count down to zero, then auto disable
		n = $urandom_range(4, 1);
		wr(`RAC_OFF_IRQ_MASK, 16'h0003, 4'hF, OK);
		wr(`RAC_OFF_ALCFG, 16'h9700 | 16'(n), 4'hF, OK);
		#1 chk(34'({alarm_interval_mask, aptr}), 34'h17);
		for (int i = 1; i <= n; i++)
		begin
			ev();
			tog = ~tog;
			pin_chk(tog);
			rd(`RAC_OFF_ALCFG, 16'h9700 | 16'(n - i), OK);
		end
		@(posedge clk_i);
		alarm_value_access_i <= 1'b1;
		@(posedge clk_i);
		alarm_value_access_i <= 1'b0;
		ev();
		tog = ~tog;
		pin_chk(tog);
		chk(34'({irq_o, aptr}), 34'h6);
		rd(`RAC_OFF_ALCFG, 16'h1600, OK);
		ev();
		pin_chk(tog);
		rd(`RAC_OFF_ALCFG, 16'h1600, OK);
		// Enabled alarm at count zero without wrap: count holds at zero
		wr(`RAC_OFF_ALCFG, 16'h8000, 4'hF, OK);
		ev();
		tog = ~tog;
		pin_chk(tog);
		rd(`RAC_OFF_ALCFG, 16'h0000, OK);
		rd(`RAC_OFF_IRQ_STAT, 16'h0003, OK);
		rd(`RAC_OFF_IRQ_STAT, 16'h0000, OK);
		#1 chk(34'(irq_o), 34'h0);
		// Wrap enabled: zero reloads to full count; masked status
		wr(`RAC_OFF_IRQ_MASK, 16'h0000, 4'hF, OK);
		wr(`RAC_OFF_ALCFG, 16'hC000, 4'hF, OK);
		ev();
		tog = ~tog;
		pin_chk(tog);
		chk(34'(irq_o), 34'h0);
		rd(`RAC_OFF_ALCFG, 16'hC0FF, OK);
		rd(`RAC_OFF_IRQ_STAT, 16'h0001, OK);
		// System reset keeps clock configuration, clears alarm
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(`RAC_OFF_CFG, 16'h0455, OK);
		rd(`RAC_OFF_ALCFG, `RAC_AL_RST, OK);
		repeat (2) @(posedge clk_i);
		close_out();
	end

endmodule // rac_top_tb_top
